// File: priv_state_pkg.sv
package priv_state_pkg;

   // Register bank layout: 64-bit registers, low word at index*8, high word at index*8+4
   localparam int unsigned BANK_COUNT = 15;
   localparam logic [3:0] IDX_ARITH_VEC = 4'h0;
   localparam logic [3:0] IDX_IFAULT_VEC = 4'h1;
   localparam logic [3:0] IDX_INTR_VEC = 4'h2;
   localparam logic [3:0] IDX_MMGMT_VEC = 4'h3;
   localparam logic [3:0] IDX_SYSCALL_VEC = 4'h4;
   localparam logic [3:0] IDX_UNALIGN_VEC = 4'h5;
   localparam logic [3:0] IDX_KERN_GPTR = 4'h6;
   localparam logic [3:0] IDX_KSTACK = 4'h7;
   localparam logic [3:0] IDX_USTACK = 4'h8;
   localparam logic [3:0] IDX_PC = 4'h9;
   localparam logic [3:0] IDX_PBLOCK = 4'hA;
   localparam logic [3:0] IDX_PTBASE = 4'hB;
   localparam logic [3:0] IDX_VTPTR = 4'hC;
   localparam logic [3:0] IDX_CPUVAL = 4'hD;
   localparam logic [3:0] IDX_PROCVAL = 4'hE;
   localparam logic [3:0] IDX_CPUNUM = 4'hF;

   // Control word holding the narrow state
   localparam logic [11:0] OFF_MISC = 12'h080;
   localparam int unsigned MISC_FLOAT_BIT = 0;
   localparam int unsigned MISC_LOCK_BIT = 1;
   localparam int unsigned MISC_INTR_BIT = 2;
   localparam int unsigned MISC_STATUS_LSB = 4;
   localparam int unsigned MISC_SPACE_LSB = 8;
   localparam int unsigned SPACE_ID_WIDTH = 8;

   // Status word fields
   localparam int unsigned STATUS_MODE_BIT = 3;
   localparam int unsigned STATUS_LEVEL_MSB = 2;
   localparam logic MODE_KERNEL = 1'b0;
   localparam logic MODE_USER = 1'b1;

   // Alignment
   localparam int unsigned PC_ZERO_BITS = 2;
   localparam int unsigned SP_ALIGN_BITS = 3;

   // Reset values
   localparam logic [63:0] RESET_WORD = 64'h0000000000000000;
   localparam logic [3:0] RESET_STATUS = 4'h0;
   localparam logic [SPACE_ID_WIDTH-1:0] RESET_SPACE_ID = 8'h00;

   typedef enum logic [2:0] {
      EXC_ARITH,
      EXC_IFAULT,
      EXC_INTR,
      EXC_MMGMT,
      EXC_SYSCALL,
      EXC_UNALIGN
   } exc_kind_t;

endpackage : priv_state_pkg

// File: apb_decode.sv
`timescale 1ns/100ps
module apb_decode
   import priv_state_pkg::*;
(
   input wire logic [11:0] paddr,
   output logic [3:0] idx,
   output logic hi_word,
   output logic is_bank,
   output logic is_misc
);

   // Bank words fill 0x000..0x07F, control word sits just above
   always_comb begin
      idx = paddr[6:3];
      hi_word = paddr[2];
      is_bank = (paddr[11:7] == 5'h00) && (paddr[1:0] == 2'h0);
      is_misc = (paddr == OFF_MISC);
   end

endmodule : apb_decode

// File: privileged_state_registers.sv
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
// Behaviour
// - Float instruction with float enable clear raises float-disabled fault.
// - Program counter low two bits read zero; writes to them dropped.
// - Status word: mode in bit 3, priority level in bits 2:0.
// - Mode bit zero is kernel, one is user.
// - Return from interrupt or system call clears interrupt-in-progress bit.
// - Kernel stack access with misaligned stack pointer starts halt.
// - Per-CPU private value reachable only in kernel mode; one per CPU.
// - Process private value reachable from user and kernel mode.
// - Exception loads kernel global pointer into global pointer register.
// - Kernel stack pointer kept in shadow while in user mode.
// - User stack pointer kept in shadow while in kernel mode.
// - Six separate dispatch vectors; each event branches to its own.
// - CPU number reads current processor identity, below processor count.
// - One reservation bit for load-locked and store-conditional.
// - Address space identifier holds current address space number.
// - Page table base holds frame number of level one table.
// - Virtual table pointer holds virtual address of first-level table.
// - Stack pointer is general register 30, top of current stack.
// - Process block base holds current process control block address.
// - Status bits 2:0 are priority level, bit 3 selects mode.
module privileged_state_registers
   import priv_state_pkg::*;
#(
   parameter int unsigned PROCESSOR_COUNT = 4,
   parameter logic [63:0] CPU_ID = 64'h0000000000000000
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic fp_instr,
   input wire logic exc_valid,
   input wire exc_kind_t exc_kind,
   input wire logic ret_valid,
   input wire logic [3:0] ret_status,
   input wire logic [63:0] stack_pointer,
   input wire logic kstack_access,
   input wire logic lock_set,
   input wire logic lock_clear,
   input wire logic pc_load,
   input wire logic [63:0] pc_next,
   output logic float_fault,
   output logic kstack_halt,
   output logic dispatch_valid,
   output logic [63:0] dispatch_addr,
   output logic gptr_load,
   output logic [63:0] global_pointer,
   output logic sp_load,
   output logic [63:0] sp_value,
   output logic [3:0] processor_status_word,
   output logic [63:0] program_counter,
   output logic reservation_bit,
   output logic intr_flag,
   output logic [SPACE_ID_WIDTH-1:0] address_space_id
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [BANK_COUNT-1:0][63:0] bank;
      logic [3:0] status;
      logic float_en;
      logic lock;
      logic intr;
      logic [SPACE_ID_WIDTH-1:0] space_id;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic float_fault;
      logic kstack_halt;
      logic dispatch_valid;
      logic [63:0] dispatch_addr;
      logic gptr_load;
      logic [63:0] gptr_value;
      logic sp_load;
      logic [63:0] sp_value;
   } state_t;

   state_t state_r;
   state_t state_nxt;
   logic [3:0] dec_idx;
   logic dec_hi;
   logic dec_bank;
   logic dec_misc;

   apb_decode i_apb_decode (
      .paddr(paddr),
      .idx(dec_idx),
      .hi_word(dec_hi),
      .is_bank(dec_bank),
      .is_misc(dec_misc)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Strip the always-zero low bits of a code address
   function automatic logic [63:0] pc_clean(input logic [63:0] v);
      pc_clean = {v[63:PC_ZERO_BITS], {PC_ZERO_BITS{1'b0}}};
   endfunction : pc_clean

   // Replace one 32-bit half of a 64-bit register
   function automatic logic [63:0] word_merge(input logic [63:0] old, input logic hi, input logic [31:0] d);
      word_merge = hi ? {d, old[31:0]} : {old[63:32], d};
   endfunction : word_merge

   // Pick one 32-bit half of a 64-bit register
   function automatic logic [31:0] word_pick(input logic [63:0] v, input logic hi);
      word_pick = hi ? v[63:32] : v[31:0];
   endfunction : word_pick

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   logic is_user;
   logic access;
   logic commit;
   logic refuse;
   logic [31:0] rd_word;
   logic [31:0] misc_word;

   assign is_user = (state_r.status[STATUS_MODE_BIT] == MODE_USER);
   // One wait state: answer flop rises at the end of the first access cycle
   assign access = psel && penable && !state_r.pready;
   assign commit = psel && penable && state_r.pready;

   // private CPU value refused outside kernel mode
   always_comb begin
      refuse = !(dec_bank || dec_misc);
      if (dec_bank && (dec_idx == IDX_CPUVAL) && is_user) begin
         refuse = 1'b1;
      end
   end

   always_comb begin
      misc_word = 32'h00000000;
      misc_word[MISC_FLOAT_BIT] = state_r.float_en;
      misc_word[MISC_LOCK_BIT] = state_r.lock;
      misc_word[MISC_INTR_BIT] = state_r.intr;
      misc_word[MISC_STATUS_LSB +: 4] = state_r.status;
      misc_word[MISC_SPACE_LSB +: SPACE_ID_WIDTH] = state_r.space_id;
   end

   // Read mux; a refused read returns zero
   always_comb begin
      rd_word = 32'h00000000;
      if (refuse) begin
         rd_word = 32'h00000000;
      end else if (dec_misc) begin
         rd_word = misc_word;
      end else if (dec_idx == IDX_CPUNUM) begin
         rd_word = word_pick(CPU_ID, dec_hi);
      end else if (dec_idx == IDX_PC) begin
         rd_word = word_pick(pc_clean(state_r.bank[dec_idx]), dec_hi);
      end else begin
         rd_word = word_pick(state_r.bank[dec_idx], dec_hi);
      end
   end

   always_comb begin
      state_nxt = state_r;
      // Event outputs are single-cycle pulses
      state_nxt.float_fault = 1'b0;
      state_nxt.kstack_halt = 1'b0;
      state_nxt.dispatch_valid = 1'b0;
      state_nxt.gptr_load = 1'b0;
      state_nxt.sp_load = 1'b0;

      // Bus answer
      state_nxt.pready = access;
      state_nxt.pslverr = access && refuse;
      if (access && !pwrite) begin
         state_nxt.prdata = rd_word;
      end

      // Software write; hardware events below override the same fields
      if (commit && pwrite && !refuse) begin
         if (dec_misc) begin
            state_nxt.float_en = pwdata[MISC_FLOAT_BIT];
            state_nxt.lock = pwdata[MISC_LOCK_BIT];
            state_nxt.intr = pwdata[MISC_INTR_BIT];
            // mode and level stored as one nibble
            state_nxt.status = pwdata[MISC_STATUS_LSB +: 4];
            state_nxt.space_id = pwdata[MISC_SPACE_LSB +: SPACE_ID_WIDTH];
         end else if (dec_idx == IDX_PC) begin
            state_nxt.bank[dec_idx] = pc_clean(word_merge(state_r.bank[dec_idx], dec_hi, pwdata));
         end else if (dec_idx != IDX_CPUNUM) begin
            // process value open to both modes
            // page table base, table pointer, block base
            state_nxt.bank[dec_idx] = word_merge(state_r.bank[dec_idx], dec_hi, pwdata);
         end
         // CPU number writes fall through untouched
      end

      // Pipeline updates the program counter
      if (pc_load) begin
         state_nxt.bank[IDX_PC] = pc_clean(pc_next);
      end

      if (fp_instr && !state_r.float_en) begin
         state_nxt.float_fault = 1'b1;
      end

      // quadword alignment check on kernel stack use
      if (kstack_access && (stack_pointer[SP_ALIGN_BITS-1:0] != 3'h0)) begin
         state_nxt.kstack_halt = 1'b1;
      end

      // Return; an exception in the same cycle takes over
      if (ret_valid && !exc_valid) begin
         state_nxt.intr = 1'b0;
         state_nxt.status = ret_status;
         if (!is_user && (ret_status[STATUS_MODE_BIT] == MODE_USER)) begin
            // save kernel stack, r30 gets user stack
            state_nxt.bank[IDX_KSTACK] = stack_pointer;
            state_nxt.sp_load = 1'b1;
            state_nxt.sp_value = state_r.bank[IDX_USTACK];
         end
      end

      if (exc_valid) begin
         // each event to its own vector
         state_nxt.dispatch_valid = 1'b1;
         unique case (exc_kind)
            EXC_ARITH: state_nxt.dispatch_addr = state_r.bank[IDX_ARITH_VEC];
            EXC_IFAULT: state_nxt.dispatch_addr = state_r.bank[IDX_IFAULT_VEC];
            EXC_INTR: state_nxt.dispatch_addr = state_r.bank[IDX_INTR_VEC];
            EXC_MMGMT: state_nxt.dispatch_addr = state_r.bank[IDX_MMGMT_VEC];
            EXC_SYSCALL: state_nxt.dispatch_addr = state_r.bank[IDX_SYSCALL_VEC];
            EXC_UNALIGN: state_nxt.dispatch_addr = state_r.bank[IDX_UNALIGN_VEC];
            default: state_nxt.dispatch_addr = state_r.bank[IDX_ARITH_VEC];
         endcase
         // global pointer from stored kernel value
         state_nxt.gptr_load = 1'b1;
         state_nxt.gptr_value = state_r.bank[IDX_KERN_GPTR];
         if (exc_kind == EXC_INTR) begin
            state_nxt.intr = 1'b1;
         end
         if (is_user) begin
            // save user stack, r30 gets kernel stack
            state_nxt.bank[IDX_USTACK] = stack_pointer;
            state_nxt.sp_load = 1'b1;
            state_nxt.sp_value = state_r.bank[IDX_KSTACK];
         end
         state_nxt.status[STATUS_MODE_BIT] = MODE_KERNEL;
      end

      // reservation bit; a set beats any clear
      if (lock_clear) begin
         state_nxt.lock = 1'b0;
      end
      if (lock_set) begin
         state_nxt.lock = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= '0;
         state_r.bank <= {BANK_COUNT{RESET_WORD}};
         state_r.status <= RESET_STATUS;
         state_r.space_id <= RESET_SPACE_ID;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign pready = state_r.pready;
   assign prdata = state_r.prdata;
   assign pslverr = state_r.pslverr;
   assign float_fault = state_r.float_fault;
   assign kstack_halt = state_r.kstack_halt;
   assign dispatch_valid = state_r.dispatch_valid;
   assign dispatch_addr = state_r.dispatch_addr;
   assign gptr_load = state_r.gptr_load;
   assign global_pointer = state_r.gptr_value;
   assign sp_load = state_r.sp_load;
   assign sp_value = state_r.sp_value;
   assign processor_status_word = state_r.status;
   assign program_counter = state_r.bank[IDX_PC];
   assign reservation_bit = state_r.lock;
   assign intr_flag = state_r.intr;
   assign address_space_id = state_r.space_id;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // fault follows a disabled float instruction
   a_float_fault_pulse: assert property (fp_instr && !state_r.float_en |=> float_fault)
      else $error("float fault missing");

   a_pc_low_zero: assert property (program_counter[1:0] == 2'h0)
      else $error("program counter low bits set");

   // halt follows misaligned kernel stack access
   a_kstack_halt_raised: assert property ((kstack_access && stack_pointer[2:0] != 3'h0) |=> kstack_halt)
      else $error("kernel stack halt missing");

   // loaded pointer equals the stored kernel value
   a_gptr_load_value: assert property (exc_valid |=> gptr_load && global_pointer == $past(state_r.bank[IDX_KERN_GPTR]))
      else $error("global pointer load wrong");

   // interrupts go to their own vector
   a_intr_dispatch_vector: assert property (exc_valid && exc_kind == EXC_INTR
      |=> dispatch_valid && dispatch_addr == $past(state_r.bank[IDX_INTR_VEC]))
      else $error("interrupt vector wrong");

   a_intr_clear_ret: assert property (ret_valid && !exc_valid |=> !intr_flag)
      else $error("interrupt flag not cleared");

   // user access to CPU value answered with error
   a_cpuval_user_refused: assert property (psel && penable && !pready && paddr[11:3] == {5'h00, IDX_CPUVAL}
      && processor_status_word[3] && paddr[1:0] == 2'h0 |=> pready && pslverr)
      else $error("private CPU value not refused");

   // user stack saved on entry from user mode
   a_user_stack_saved: assert property (exc_valid && processor_status_word[3]
      |=> state_r.bank[IDX_USTACK] == $past(stack_pointer) && !processor_status_word[3])
      else $error("user stack not saved");

   a_cpu_id_range: assert property (CPU_ID < 64'(PROCESSOR_COUNT))
      else $error("processor identity out of range");

   a_lock_set_wins: assert property (lock_set |=> reservation_bit)
      else $error("reservation set lost");

endmodule : privileged_state_registers

// File: tb_privileged_state_registers.sv
`timescale 1ns/100ps
module tb_privileged_state_registers
   import priv_state_pkg::*;
;
   localparam logic [63:0] TB_CPU_ID = 64'h0000000000000002;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic pready, pslverr, float_fault, kstack_halt, dispatch_valid, gptr_load, sp_load;
   logic reservation_bit, intr_flag;
   logic [31:0] prdata;
   logic [63:0] dispatch_addr, global_pointer, sp_value, program_counter;
   logic [3:0] processor_status_word;
   logic [SPACE_ID_WIDTH-1:0] address_space_id;
   logic fp_instr = 1'b0, exc_valid = 1'b0, ret_valid = 1'b0, kstack_access = 1'b0;
   logic lock_set = 1'b0, lock_clear = 1'b0, pc_load = 1'b0;
   exc_kind_t exc_kind = EXC_ARITH;
   logic [3:0] ret_status = 4'h0;
   logic [63:0] stack_pointer = 64'h0000000000000000, pc_next = 64'h0000000000000000;
   int error_cnt = 0;
   int tests_run = 0;
   logic [31:0] rd;
   logic err;
   logic [63:0] v;

   privileged_state_registers #(.PROCESSOR_COUNT(4), .CPU_ID(TB_CPU_ID)) i_privileged_state_registers (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .fp_instr(fp_instr),
      .exc_valid(exc_valid), .exc_kind(exc_kind), .ret_valid(ret_valid), .ret_status(ret_status),
      .stack_pointer(stack_pointer), .kstack_access(kstack_access), .lock_set(lock_set),
      .lock_clear(lock_clear), .pc_load(pc_load), .pc_next(pc_next), .float_fault(float_fault),
      .kstack_halt(kstack_halt), .dispatch_valid(dispatch_valid), .dispatch_addr(dispatch_addr),
      .gptr_load(gptr_load), .global_pointer(global_pointer), .sp_load(sp_load), .sp_value(sp_value),
      .processor_status_word(processor_status_word), .program_counter(program_counter),
      .reservation_bit(reservation_bit), .intr_flag(intr_flag), .address_space_id(address_space_id)
   );

   // Free-running 125 MHz clock
   always #4 pclk = ~pclk;

   ////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task tick;
      @(posedge pclk);
   endtask : tick

   task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // One APB transfer; caller is just past an edge, one idle cycle after so psel never double-drives
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      tick;
      penable <= 1'b1;
      // Wait for the answer; only the watchdog ends a hang
      do begin
         tick;
      end while (pready !== 1'b1);
      chk("pready", pready, 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      tick;
   endtask : apb

   task wr64(input int idx, input logic [63:0] val);
      apb(1'b1, 12'(idx * 8), val[31:0]);
      apb(1'b1, 12'(idx * 8 + 4), val[63:32]);
   endtask : wr64

   task rd64(input int idx);
      apb(1'b0, 12'(idx * 8), 32'h00000000);
      v[31:0] = rd;
      apb(1'b0, 12'(idx * 8 + 4), 32'h00000000);
      v[63:32] = rd;
   endtask : rd64

   // Exception pulse, then the dispatch and global pointer outputs one cycle on
   task exc(input int k, input logic [63:0] vec, input logic [63:0] kernel_global_ptr);
      exc_valid <= 1'b1;
      exc_kind <= exc_kind_t'(k);
      tick;
      exc_valid <= 1'b0;
      tick;
      chk("dispatch_valid", dispatch_valid, 1'b1);
      chk("dispatch_addr", dispatch_addr, vec);
      chk("gptr_load", gptr_load, 1'b1);
      chk("global_pointer", global_pointer, kernel_global_ptr);
   endtask : exc

   task done(input string nm);
      $display("test %s finished, %0d compares, %0d mismatches", nm, tests_run, error_cnt);
   endtask : done

   task give_verdict;
      $display("compares %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (16) tick;
      presetn <= 1'b1;
      tick;
      // Reset state: kernel, level zero
      apb(1'b0, OFF_MISC, 32'h00000000);
      chk("misc reset", rd, 32'h00000000);
      chk("psw reset", processor_status_word, 4'h0);
      done("reset");
      // Every dispatch vector distinct, each exception kind picks its own
      for (int i = 0; i < 6; i++) wr64(i, 64'hC0DE000000001000 | (64'(i) << 36) | (64'(i) << 4));
      wr64(6, 64'h123456789ABCDEF0);
      for (int i = 0; i < 6; i++) exc(i, 64'hC0DE000000001000 | (64'(i) << 36) | (64'(i) << 4), 64'h123456789ABCDEF0);
      chk("intr_flag", intr_flag, 1'b1);
      done("vectors");
      // Low two counter bits are dropped on both paths
      wr64(9, 64'h0123456789ABCDEF);
      chk("pc out", program_counter, 64'h0123456789ABCDEC);
      rd64(9);
      chk("pc read", v, 64'h0123456789ABCDEC);
      pc_load <= 1'b1;
      pc_next <= 64'hFFFF000000000403;
      tick;
      pc_load <= 1'b0;
      tick;
      chk("pc load", program_counter, 64'hFFFF000000000400);
      done("pc");
      // Float fault only while enable is clear
      for (int f = 0; f < 2; f++) begin
         apb(1'b1, OFF_MISC, 32'(f));
         fp_instr <= 1'b1;
         tick;
         fp_instr <= 1'b0;
         tick;
         chk("float_fault", float_fault, logic'(f == 0));
      end
      // Misaligned kernel stack halts, quadword aligned does not
      for (int s = 0; s < 2; s++) begin
         stack_pointer <= s ? 64'h0000000000008008 : 64'h0000000000008004;
         kstack_access <= 1'b1;
         tick;
         kstack_access <= 1'b0;
         tick;
         chk("kstack_halt", kstack_halt, logic'(s == 0));
      end
      done("faults");
      // User mode, level 2, asid 5: CPU private refused, process private allowed
      wr64(7, 64'hAAAA00000000A000);
      wr64(8, 64'hBBBB00000000B000);
      apb(1'b1, OFF_MISC, 32'h000005A1);
      chk("psw", processor_status_word, 4'hA);
      chk("asid", address_space_id, 8'h05);
      apb(1'b0, 12'h068, 32'h00000000);
      chk("cpuval err", err, 1'b1);
      wr64(14, 64'h5555666677778888);
      rd64(14);
      chk("procval", v, 64'h5555666677778888);
      chk("procval err", err, 1'b0);
      done("user");
      // Interrupt from user mode swaps stacks and drops to kernel
      stack_pointer <= 64'h00000000CCCC0000;
      exc(2, 64'hC0DE000000001000 | (64'(2) << 36) | (64'(2) << 4), 64'h123456789ABCDEF0);
      chk("sp kernel", sp_value, 64'hAAAA00000000A000);
      chk("sp_load", sp_load, 1'b1);
      chk("psw kernel", processor_status_word, 4'h2);
      rd64(8);
      chk("user shadow", v, 64'h00000000CCCC0000);
      wr64(13, 64'h0F0F0F0F0F0F0F0F);
      rd64(13);
      chk("cpuval", v, 64'h0F0F0F0F0F0F0F0F);
      // Return to user clears the flag and restores the user stack
      stack_pointer <= 64'h00000000DDDD0000;
      ret_valid <= 1'b1;
      ret_status <= 4'h8;
      tick;
      ret_valid <= 1'b0;
      tick;
      chk("psw user", processor_status_word, 4'h8);
      chk("intr clr", intr_flag, 1'b0);
      chk("sp user", sp_value, 64'h00000000CCCC0000);
      rd64(7);
      chk("kernel shadow", v, 64'h00000000DDDD0000);
      done("swap");
      // CPU number read-only; reservation bit set and cleared
      wr64(15, 64'hFFFFFFFFFFFFFFFF);
      chk("cpunum wr err", err, 1'b0);
      rd64(15);
      chk("cpunum", v, TB_CPU_ID);
      lock_set <= 1'b1;
      tick;
      lock_set <= 1'b0;
      tick;
      chk("lock set", reservation_bit, 1'b1);
      lock_clear <= 1'b1;
      tick;
      lock_clear <= 1'b0;
      tick;
      chk("lock clr", reservation_bit, 1'b0);
      // Unmapped and misaligned addresses refused
      apb(1'b0, 12'h100, 32'h00000000);
      chk("unmapped err", err, 1'b1);
      apb(1'b1, 12'h002, 32'h12345678);
      chk("misaligned err", err, 1'b1);
      done("misc");
      give_verdict;
   end

   // Watchdog well beyond the few hundred cycles the sequence needs
   initial begin
      repeat (20000) tick;
      error_cnt++;
      give_verdict;
   end

endmodule : tb_privileged_state_registers
